// ---- hdl/sbc_top.sv ----
// Notes on behaviour
// - Match flag shows slave address equals shift
// - Enable bit stops or permits channel operation
// - Disabled channel forces match flag low
// - Release trigger sets output latch, self-clears
// - Release or stop condition sets release flag in serial-bus or two-wire mode
// - Release flag clears: start, mismatch, disable, reset
// - Command condition sets command flag in serial-bus or two-wire mode
// - Command flag clears: start, release, disable, reset
// - Serial-bus acknowledge on next falling clock, self-clears
// - Acknowledge trigger clears on transfer start, disable
// - Two-wire acknowledge holds data low until falling
// - Detect flags in control register are read-only
// - Trigger bits read zero once action completes
// - Enable bit sits at bit seven of mode
`timescale 1ns/100ps
`default_nettype none
`include "sbc_map.svh"
module sbc_top
  import sbc_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic linkClk,
  // Wishbone slave, byte address
  input wire logic [17:0] adr_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  input wire logic we_i,
  input wire logic [3:0] sel_i,
  input wire logic stb_i,
  input wire logic cyc_i,
  output logic ack_o,
  // Shift datapath, same clock
  input wire logic addrRxDone,
  input wire logic [7:0] rxByte,
  input wire logic ackSeen,
  // Serial bus pins
  input wire logic serialClockPin,
  input wire logic serialDataPinAIn,
  output logic serialDataPinAOut,
  output logic serialDataPinAOe
);
  sbc_top_t s; // Whole register-side state
  sbc_top_t next_s; // Its next value

  // Bus decode
  logic busReq; // A request not yet answered
  logic wrStb; // Write to the low byte lane
  logic [15:0] regIdx; // Word index of the access
  logic hitMode;
  logic hitCtrl;
  logic hitSaddr;
  logic hitShift;
  logic [7:0] wByte; // Write data of the low lane

  // Events coming back from the link
  logic [2:0] evSync; // Synchronised toggles
  logic [2:0] evPulse; // One-cycle events
  logic startEv; // Command / start seen
  logic stopEv; // Release / stop seen
  logic ackDone; // Acknowledge bit finished
  logic xferStart; // Transfer start instruction
  logic mismatch; // Received address differs
  logic busMode; // Serial-bus or two-wire mode
  logic i2cMode; // Two-wire mode selected
  logic [7:0] modeRd;
  logic [7:0] ctrlRd;

  logic startTglL; // Toggle outputs of the link side
  logic stopTglL;
  logic ackDoneTglL;

  // Link toggles cross as toggles and become pulses here
  sbc_sync #(.W(3)) uEvSync (
    .clk(clk),
    .d({startTglL, stopTglL, ackDoneTglL}),
    .q(evSync)
  );

  // Link-side logic on its own clock
  sbc_link uLink (
    .linkClk(linkClk),
    .reset(reset),
    .enable(s.enable),
    .i2cMode(i2cMode),
    .outLatch(s.outLatch),
    .ackReqTgl(s.ackReqTgl),
    .serialClockPin(serialClockPin),
    .serialDataPinAIn(serialDataPinAIn),
    .startTgl(startTglL),
    .stopTgl(stopTglL),
    .ackDoneTgl(ackDoneTglL),
    .serialDataPinAOut(serialDataPinAOut),
    .serialDataPinAOe(serialDataPinAOe)
  );

  // Mode decode from the stored selection
  assign busMode = s.modeSel[`SBC_MODE_SEL_HI];
  assign i2cMode = s.modeSel[`SBC_MODE_SEL_HI] & s.modeSel[`SBC_MODE_SEL_LO];

  // Address decode and strobes
  always_comb begin
    busReq = cyc_i & stb_i & ~s.ack;
    wrStb = busReq & we_i & sel_i[0];
    regIdx = adr_i[17:2];
    hitMode = (regIdx == `SBC_IDX_MODE);
    hitCtrl = (regIdx == `SBC_IDX_CTRL);
    hitSaddr = (regIdx == `SBC_IDX_SADDR);
    hitShift = (regIdx == `SBC_IDX_SHIFT);
    wByte = dat_i[7:0];
  end

  // Event pulses and the conditions built on them
  always_comb begin
    evPulse = evSync ^ s.evSeen;
    startEv = evPulse[2];
    stopEv = evPulse[1];
    ackDone = evPulse[0];
    // Writing the shift register starts a transfer
    xferStart = wrStb & hitShift;
    mismatch = addrRxDone & (rxByte != s.slaveAddr);
  end

  // Read views of the two mixed registers
  always_comb begin
    modeRd = '0;
    modeRd[`SBC_MODE_EN] = s.enable;
    modeRd[`SBC_MODE_MATCH] = s.matchFlag;
    modeRd[`SBC_MODE_WAKE] = s.wake;
    modeRd[4:0] = s.modeSel;
    ctrlRd = '0;
    ctrlRd[`SBC_CTRL_REL_T] = s.release_trigger;
    ctrlRd[`SBC_CTRL_CMD_T] = s.command_trigger;
    ctrlRd[`SBC_CTRL_REL_D] = s.release_detect_flag;
    ctrlRd[`SBC_CTRL_CMD_D] = s.command_detect_flag;
    ctrlRd[`SBC_CTRL_ACK_T] = s.ack_trigger;
    ctrlRd[`SBC_CTRL_ACK_E] = s.auto_ack_enable;
    ctrlRd[`SBC_CTRL_ACK_D] = s.ack_detect_flag;
    ctrlRd[`SBC_CTRL_BSY_E] = s.busy_output_enable;
  end

  // Next-state logic
  always_comb begin
    next_s = s;
    next_s.evSeen = evSync;

    // Answer every request one cycle after it appears
    next_s.ack = busReq;
    next_s.rdata = '0;
    if (busReq && !we_i) begin
      if (hitMode) begin
        next_s.rdata[7:0] = modeRd;
      end else if (hitCtrl) begin
        next_s.rdata[7:0] = ctrlRd;
      end else if (hitSaddr) begin
        next_s.rdata[7:0] = s.slaveAddr;
      end else if (hitShift) begin
        next_s.rdata[7:0] = s.shiftReg;
      end
    end

    // Mode register; the match flag is not writable
    if (wrStb && hitMode) begin
      next_s.enable = wByte[`SBC_MODE_EN];
      next_s.wake = wByte[`SBC_MODE_WAKE];
      next_s.modeSel = wByte[4:0];
    end

    // Slave address register
    if (wrStb && hitSaddr) begin
      next_s.slaveAddr = wByte;
    end

    // Shift register: software write or received address byte
    if (xferStart) begin
      next_s.shiftReg = wByte;
    end else if (addrRxDone) begin
      next_s.shiftReg = rxByte;
    end

    // Pending triggers act one cycle after being written
    if (s.release_trigger) begin
      next_s.outLatch = 1'b1;
      next_s.release_trigger = 1'b0;
    end
    if (s.command_trigger) begin
      next_s.outLatch = 1'b0;
      next_s.command_trigger = 1'b0;
    end

    // Acknowledge bit finished on the link
    if (ackDone) begin
      next_s.ack_trigger = 1'b0;
    end
    // Transfer start clears the trigger of an unsent acknowledge
    if (xferStart) begin
      next_s.ack_trigger = 1'b0;
    end

    // Control register; detect flags ignore writes
    if (wrStb && hitCtrl) begin
      if (wByte[`SBC_CTRL_REL_T]) begin
        next_s.release_trigger = 1'b1;
      end
      if (wByte[`SBC_CTRL_CMD_T]) begin
        next_s.command_trigger = 1'b1;
      end
      // A new acknowledge request goes out as a toggle
      if (wByte[`SBC_CTRL_ACK_T] && !s.ack_trigger) begin
        next_s.ack_trigger = 1'b1;
        next_s.ackReqTgl = ~s.ackReqTgl;
      end
      next_s.auto_ack_enable = wByte[`SBC_CTRL_ACK_E];
      next_s.busy_output_enable = wByte[`SBC_CTRL_BSY_E];
    end

    // Release detect: cleared by start or mismatch, set wins
    if (xferStart || mismatch) begin
      next_s.release_detect_flag = 1'b0;
    end
    if (stopEv && busMode) begin
      next_s.release_detect_flag = 1'b1;
    end

    // Command detect: cleared by start or release, set wins
    if (xferStart || stopEv) begin
      next_s.command_detect_flag = 1'b0;
    end
    if (startEv && busMode) begin
      next_s.command_detect_flag = 1'b1;
    end

    // Acknowledge detect from the shift datapath
    if (xferStart) begin
      next_s.ack_detect_flag = 1'b0;
    end
    if (ackSeen) begin
      next_s.ack_detect_flag = 1'b1;
    end

    // A stopped channel holds triggers and flags at zero
    if (!next_s.enable) begin
      next_s.release_trigger = 1'b0;
      next_s.command_trigger = 1'b0;
      next_s.ack_trigger = 1'b0;
      next_s.release_detect_flag = 1'b0;
      next_s.command_detect_flag = 1'b0;
      next_s.ack_detect_flag = 1'b0;
    end

    // Address comparison, forced low while stopped
    next_s.matchFlag = next_s.enable & (next_s.slaveAddr == next_s.shiftReg);

    // Reset values; the output latch rests released
    if (reset) begin
      next_s = '0;
      next_s.enable = 1'(`SBC_RST_MODE >> `SBC_MODE_EN);
      next_s.slaveAddr = `SBC_RST_SADDR;
      next_s.shiftReg = `SBC_RST_SHIFT;
      next_s.outLatch = 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    s <= next_s;
  end

  // Bus outputs straight from the state
  assign ack_o = s.ack;
  assign dat_o = s.rdata;
endmodule : sbc_top
`default_nettype wire

// ---- hdl/sbc_map.svh ----
`ifndef SBC_MAP_SVH
`define SBC_MAP_SVH
// Register indices; the byte address of a register is four times its index
`define SBC_IDX_MODE 16'hff60
`define SBC_IDX_CTRL 16'hff61
`define SBC_IDX_SADDR 16'hff62
`define SBC_IDX_SHIFT 16'hff64
// Reset values
`define SBC_RST_MODE 8'h00
`define SBC_RST_CTRL 8'h00
`define SBC_RST_SADDR 8'h00
`define SBC_RST_SHIFT 8'h00
// Channel mode register fields
`define SBC_MODE_EN 7
`define SBC_MODE_MATCH 6
`define SBC_MODE_WAKE 5
`define SBC_MODE_SEL_HI 4
`define SBC_MODE_SEL_LO 3
// Bus control register fields
`define SBC_CTRL_REL_T 0
`define SBC_CTRL_CMD_T 1
`define SBC_CTRL_REL_D 2
`define SBC_CTRL_CMD_D 3
`define SBC_CTRL_ACK_T 4
`define SBC_CTRL_ACK_E 5
`define SBC_CTRL_ACK_D 6
`define SBC_CTRL_BSY_E 7
`endif

// ---- hdl/sbc_pkg.sv ----
package sbc_pkg;
  // Acknowledge drive sequencer on the link side
  typedef enum logic [1:0] {
    SBC_ACK_IDLE = 2'b00,
    SBC_ACK_WAIT = 2'b01,
    SBC_ACK_HOLD = 2'b11
  } sbc_ack_t;

  // Link-side state
  typedef struct packed {
    logic sclPrev;
    logic sdaPrev;
    logic ackSeen;
    sbc_ack_t ackState;
    logic startTgl;
    logic stopTgl;
    logic ackDoneTgl;
    logic pinOut;
    logic pinOe;
  } sbc_link_t;

  // Register-side state
  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic enable;
    logic wake;
    logic [4:0] modeSel;
    logic matchFlag;
    logic [7:0] slaveAddr;
    logic [7:0] shiftReg;
    logic release_trigger;
    logic command_trigger;
    logic release_detect_flag;
    logic command_detect_flag;
    logic ack_trigger;
    logic auto_ack_enable;
    logic ack_detect_flag;
    logic busy_output_enable;
    logic outLatch;
    logic ackReqTgl;
    logic [2:0] evSeen;
  } sbc_top_t;
endpackage : sbc_pkg

// ---- hdl/sbc_sync.sv ----
`timescale 1ns/100ps
`default_nettype none
// Two-stage synchroniser; only the second stage is visible
module sbc_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  // Both stages in one state word
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] held;
  } sbc_sync_t;

  sbc_sync_t s;
  sbc_sync_t next_s;

  // Shift the samples along
  always_comb begin
    next_s.meta = d;
    next_s.held = s.meta;
  end

  // Stage registers
  always_ff @(posedge clk) begin
    s <= next_s;
  end

  assign q = s.held;
endmodule : sbc_sync
`default_nettype wire

// ---- hdl/sbc_link.sv ----
`timescale 1ns/100ps
`default_nettype none
// Link-side logic: condition detection and data-line drive
module sbc_link
  import sbc_pkg::*;
(
  input wire logic linkClk,
  input wire logic reset,
  input wire logic enable,
  input wire logic i2cMode,
  input wire logic outLatch,
  input wire logic ackReqTgl,
  input wire logic serialClockPin,
  input wire logic serialDataPinAIn,
  output logic startTgl,
  output logic stopTgl,
  output logic ackDoneTgl,
  output logic serialDataPinAOut,
  output logic serialDataPinAOe
);
  logic [6:0] syn; // Synchronised copies of every foreign input
  logic rstL, enL, i2cL, latchL, ackL, sclL, sdaL;
  logic fallEdge, startEv, stopEv;
  sbc_link_t s;
  sbc_link_t next_s;

  // Everything from the register domain or the pins crosses here
  sbc_sync #(.W(7)) uSync (
    .clk(linkClk),
    .d({reset, enable, i2cMode, outLatch, ackReqTgl, serialClockPin, serialDataPinAIn}),
    .q(syn)
  );
  assign {rstL, enL, i2cL, latchL, ackL, sclL, sdaL} = syn;

  // Next-state logic
  always_comb begin
    next_s = s;
    fallEdge = s.sclPrev & ~sclL;
    // Data falls while clock high: command / start
    startEv = enL & sclL & s.sclPrev & s.sdaPrev & ~sdaL;
    // Data rises while clock high: release / stop
    stopEv = enL & sclL & s.sclPrev & ~s.sdaPrev & sdaL;
    next_s.sclPrev = sclL;
    next_s.sdaPrev = sdaL;
    if (startEv) begin
      next_s.startTgl = ~s.startTgl;
    end
    if (stopEv) begin
      next_s.stopTgl = ~s.stopTgl;
    end
    unique case (s.ackState)
      SBC_ACK_IDLE: begin
        // New request; two-wire mode pulls low at once
        if (enL && (ackL != s.ackSeen)) begin
          next_s.ackSeen = ackL;
          next_s.ackState = i2cL ? SBC_ACK_HOLD : SBC_ACK_WAIT;
        end
      end
      SBC_ACK_WAIT: begin
        // Serial-bus mode starts the bit on the next falling edge
        if (fallEdge) begin
          next_s.ackState = SBC_ACK_HOLD;
        end
      end
      SBC_ACK_HOLD: begin
        // Released at the following falling edge, then reported back
        if (fallEdge) begin
          next_s.ackState = SBC_ACK_IDLE;
          next_s.ackDoneTgl = ~s.ackDoneTgl;
        end
      end
      default: begin
        next_s.ackState = SBC_ACK_IDLE;
      end
    endcase
    // A stopped channel drops any pending acknowledge
    if (!enL) begin
      next_s.ackSeen = ackL;
      next_s.ackState = SBC_ACK_IDLE;
    end
    // Open-drain: pull low for a cleared latch or an acknowledge
    next_s.pinOut = 1'b0;
    next_s.pinOe = enL & (~latchL | (next_s.ackState == SBC_ACK_HOLD));
    if (rstL) begin
      next_s = '0;
    end
  end

  // State register
  always_ff @(posedge linkClk) begin
    s <= next_s;
  end

  assign startTgl = s.startTgl;
  assign stopTgl = s.stopTgl;
  assign ackDoneTgl = s.ackDoneTgl;
  assign serialDataPinAOut = s.pinOut;
  assign serialDataPinAOe = s.pinOe;
endmodule : sbc_link
`default_nettype wire

// ---- verif/sbc_assertions.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "sbc_map.svh"
// Port checker for the serial bus flag block
module sbc_assertions (
  input wire logic clk,
  input wire logic reset,
  input wire logic linkClk,
  input wire logic [17:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic we_i,
  input wire logic [3:0] sel_i,
  input wire logic stb_i,
  input wire logic cyc_i,
  input wire logic ack_o,
  input wire logic serialDataPinAOut,
  input wire logic serialDataPinAOe
);
  wire logic [15:0] idx = adr_i[17:2]; // Register index
  wire logic wr = ack_o & we_i & sel_i[0]; // Accepted write
  logic en; // Enable as last written
  logic latch; // Output latch as last triggered
  logic [4:0] quiet; // Cycles since enable or latch could change
  // Track enable and latch from bus writes
  always_ff @(posedge clk) begin
    if (reset) begin
      en <= 1'b0;
      latch <= 1'b1;
    end else if (wr && idx == `SBC_IDX_MODE) begin
      en <= dat_i[7];
      latch <= latch | ~dat_i[7];
    end else if (wr && idx == `SBC_IDX_CTRL && en) begin
      latch <= dat_i[0] | (latch & ~dat_i[1]);
    end
  end
  // Settling counter, long enough for the link synchroniser
  always_ff @(posedge clk) begin
    if (reset || (wr && (idx == `SBC_IDX_MODE || idx == `SBC_IDX_CTRL))) begin
      quiet <= 5'h00;
    end else if (quiet != 5'h1f) begin
      quiet <= quiet + 5'h01;
    end
  end
  sequence modeRd;
    ack_o && !we_i && idx == `SBC_IDX_MODE;
  endsequence
  sequence ctrlRd;
    ack_o && !we_i && idx == `SBC_IDX_CTRL;
  endsequence
  ack_resp_a:
    assert property (@(posedge clk) disable iff (reset) cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("Bus request not answered next cycle");
  ack_drop_a:
    assert property (@(posedge clk) disable iff (reset) ack_o |=> !ack_o)
    else $error("Bus answer longer than one cycle");
  rdata_idle_a:
    assert property (@(posedge clk) disable iff (reset) !ack_o |-> dat_o == 32'h00000000)
    else $error("Read data not zero outside an answer");
  rdata_lane_a:
    assert property (@(posedge clk) disable iff (reset) ack_o |-> dat_o[31:8] == 24'h000000)
    else $error("Upper read lanes not zero");
  match_off_a:
    assert property (@(posedge clk) disable iff (reset) modeRd |-> !(dat_o[6] && !dat_o[7]))
    else $error("Match flag set while disabled");
  enable_bit_a:
    assert property (@(posedge clk) disable iff (reset) modeRd |-> dat_o[7] == en)
    else $error("Enable bit read back wrong");
  trig_zero_a:
    assert property (@(posedge clk) disable iff (reset) ctrlRd |-> dat_o[1:0] == 2'b00)
    else $error("Latch trigger still reads one");
  pin_low_a:
    assert property (@(posedge linkClk) disable iff (reset) serialDataPinAOut == 1'b0)
    else $error("Data output not low");
  off_release_a:
    assert property (@(posedge linkClk) disable iff (reset)
      quiet == 5'h1f && !en |-> !serialDataPinAOe)
    else $error("Data line pulled while disabled");
  cmd_drive_a:
    assert property (@(posedge linkClk) disable iff (reset)
      quiet == 5'h1f && en && !latch |-> serialDataPinAOe)
    else $error("Cleared latch does not pull data low");
endmodule : sbc_assertions
`default_nettype wire

// ---- verif/sbc_bus_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// Other bus party: owns the clock line, may pull data low
module sbc_bus_model (
  input wire logic dutOe,
  output logic sclLine,
  output logic sdaLine
);
  logic pullLow; // Own open-drain pull on data
  // Pulled-up data line, low if any party pulls
  assign sdaLine = ~(pullLow | dutOe);
  initial begin
    sclLine = 1'b1;
    pullLow = 1'b0;
  end
  // Move the clock line and let it stand
  task automatic set_scl(input logic v);
    sclLine = v;
    #200;
  endtask : set_scl
  // Data falls while the clock stands high
  task automatic send_start;
    pullLow = 1'b1;
    #200;
  endtask : send_start
  // Data rises while the clock stands high
  task automatic send_stop;
    pullLow = 1'b0;
    #200;
  endtask : send_stop
endmodule : sbc_bus_model
`default_nettype wire

// ---- verif/tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "sbc_map.svh"
module tb_top;
  logic clk, linkClk, reset, we_i, stb_i, cyc_i, addrRxDone, ackSeen;
  logic [17:0] adr_i;
  logic [31:0] dat_i;
  logic [3:0] sel_i;
  logic [7:0] rxByte, q, a;
  logic [7:0] md [3]; // Serial-bus, two-wire, no bus mode
  wire logic [31:0] dat_o;
  wire logic ack_o, scl, sda, pinOut, pinOe;
  int num_errors, checked, cycles;
  sbc_top dut (.clk(clk), .reset(reset), .linkClk(linkClk), .adr_i(adr_i), .dat_i(dat_i),
    .dat_o(dat_o), .we_i(we_i), .sel_i(sel_i), .stb_i(stb_i), .cyc_i(cyc_i), .ack_o(ack_o),
    .addrRxDone(addrRxDone), .rxByte(rxByte), .ackSeen(ackSeen), .serialClockPin(scl),
    .serialDataPinAIn(sda), .serialDataPinAOut(pinOut), .serialDataPinAOe(pinOe));
  sbc_bus_model peer (.dutOe(pinOe), .sclLine(scl), .sdaLine(sda));
  // Clocks: 8 ns system, 32 ns link with a phase offset
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    linkClk = 1'b0;
    #3;
    forever #16 linkClk = ~linkClk;
  end
  // Cut a hang short
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      give_verdict();
    end
  end
  task automatic give_verdict;
    $display("Mismatches %0d, comparisons %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : give_verdict
  task automatic cmp_reg(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %0t register %h expected %h", $time, got, exp);
    end
  endtask : cmp_reg
  task automatic cmp_pin(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %0t data pull %b expected %b", $time, got, exp);
    end
  endtask : cmp_pin
  // One classic bus cycle, then one idle cycle
  task automatic wb(input logic [15:0] idx, input logic w, input logic [7:0] d);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    // Upper lanes and selects carry noise the block must ignore
    sel_i <= {3'($urandom), 1'b1};
    adr_i <= {idx, 2'($urandom)};
    dat_i <= {24'($urandom), d};
    do begin
      @(posedge clk);
    end while (ack_o !== 1'b1);
    cmp_pin(ack_o, 1'b1);
    q = dat_o[7:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk);
  endtask : wb
  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    wb(idx, 1'b1, d);
  endtask : wr
  task automatic rd(input logic [15:0] idx, input logic [7:0] exp);
    wb(idx, 1'b0, 8'h00);
    cmp_reg(q, exp);
  endtask : rd
  // Link crossing latency, a few link cycles
  task automatic settle;
    repeat (24) @(posedge clk);
  endtask : settle
  // Received address byte from the shift path
  task automatic rx(input logic [7:0] b);
    rxByte <= b;
    addrRxDone <= 1'b1;
    @(posedge clk);
    addrRxDone <= 1'b0;
    @(posedge clk);
  endtask : rx
  // Control value expected with storage bits set
  function automatic logic [7:0] flags(input int m, input logic [7:0] f);
    return (m < 2) ? (8'ha0 | f) : 8'ha0;
  endfunction : flags
  initial begin
    {num_errors, checked, cycles} = '0;
    {we_i, stb_i, cyc_i, addrRxDone, ackSeen} = '0;
    {adr_i, dat_i, sel_i, rxByte} = '0;
    reset = 1'b1;
    md = '{8'h90, 8'h98, 8'h80};
    void'($urandom(32'h082432a7));
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    rd(`SBC_IDX_MODE, 8'h00);
    rd(`SBC_IDX_CTRL, 8'h00);
    wr(16'hff63, 8'h5a);
    rd(16'hff63, 8'h00);
    // Match flag against random addresses
    for (int i = 0; i < 6; i++) begin
      a = 8'($urandom);
      wr(`SBC_IDX_SADDR, a);
      wr(`SBC_IDX_MODE, 8'h90);
      wr(`SBC_IDX_SHIFT, i[0] ? a : a ^ (8'($urandom) | 8'h01));
      rd(`SBC_IDX_MODE, i[0] ? 8'hd0 : 8'h90);
    end
    wr(`SBC_IDX_MODE, 8'h10);
    rd(`SBC_IDX_MODE, 8'h10);
    wr(`SBC_IDX_MODE, 8'h90);
    wr(`SBC_IDX_CTRL, 8'he4);
    rd(`SBC_IDX_CTRL, 8'ha0);
    // Latch triggers with the clock held low
    peer.set_scl(1'b0);
    settle;
    wr(`SBC_IDX_CTRL, 8'ha2);
    rd(`SBC_IDX_CTRL, 8'ha0);
    settle;
    cmp_pin(pinOe, 1'b1);
    wr(`SBC_IDX_MODE, 8'h10);
    settle;
    cmp_pin(pinOe, 1'b0);
    wr(`SBC_IDX_MODE, 8'h90);
    wr(`SBC_IDX_CTRL, 8'ha1);
    settle;
    cmp_pin(pinOe, 1'b0);
    // Software acknowledge, serial-bus mode
    wr(`SBC_IDX_CTRL, 8'hb0);
    rd(`SBC_IDX_CTRL, 8'hb0);
    settle;
    for (int k = 0; k < 2; k++) begin
      peer.set_scl(1'b1);
      peer.set_scl(1'b0);
      settle;
      cmp_pin(pinOe, k == 0);
    end
    rd(`SBC_IDX_CTRL, 8'ha0);
    wr(`SBC_IDX_CTRL, 8'hb0);
    wr(`SBC_IDX_SHIFT, 8'h00);
    rd(`SBC_IDX_CTRL, 8'ha0);
    wr(`SBC_IDX_CTRL, 8'hb0);
    wr(`SBC_IDX_MODE, 8'h18);
    rd(`SBC_IDX_CTRL, 8'ha0);
    // Software acknowledge, two-wire mode
    wr(`SBC_IDX_MODE, 8'h98);
    wr(`SBC_IDX_CTRL, 8'hb0);
    settle;
    cmp_pin(pinOe, 1'b1);
    peer.set_scl(1'b1);
    peer.set_scl(1'b0);
    settle;
    cmp_pin(pinOe, 1'b0);
    rd(`SBC_IDX_CTRL, 8'ha0);
    peer.set_scl(1'b1);
    settle;
    // Detect flags in every mode
    for (int m = 0; m < 3; m++) begin
      wr(`SBC_IDX_MODE, md[m]);
      peer.send_start();
      settle;
      rd(`SBC_IDX_CTRL, flags(m, 8'h08));
      peer.send_stop();
      settle;
      rd(`SBC_IDX_CTRL, flags(m, 8'h04));
      wr(`SBC_IDX_SHIFT, 8'h00);
      rd(`SBC_IDX_CTRL, 8'ha0);
      peer.send_start();
      peer.send_stop();
      settle;
      rx(~a);
      rd(`SBC_IDX_CTRL, 8'ha0);
      peer.send_start();
      settle;
      wr(`SBC_IDX_SHIFT, 8'h00);
      rd(`SBC_IDX_CTRL, 8'ha0);
      peer.send_stop();
      peer.send_start();
      settle;
      wr(`SBC_IDX_MODE, md[m] & 8'h7f);
      rd(`SBC_IDX_CTRL, 8'ha0);
      peer.send_stop();
      settle;
    end
    // Acknowledge detect flag
    wr(`SBC_IDX_MODE, 8'h90);
    ackSeen <= 1'b1;
    @(posedge clk);
    ackSeen <= 1'b0;
    @(posedge clk);
    wr(`SBC_IDX_CTRL, 8'ha0);
    rd(`SBC_IDX_CTRL, 8'he0);
    wr(`SBC_IDX_MODE, 8'h10);
    rd(`SBC_IDX_CTRL, 8'ha0);
    give_verdict();
  end
endmodule : tb_top
bind sbc_top sbc_assertions chk (.clk(clk), .reset(reset), .linkClk(linkClk),
  .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o), .we_i(we_i), .sel_i(sel_i), .stb_i(stb_i),
  .cyc_i(cyc_i), .ack_o(ack_o), .serialDataPinAOut(serialDataPinAOut),
  .serialDataPinAOe(serialDataPinAOe));
`default_nettype wire
